//--- verilog/spfc_pkg.sv
// Constants, register map and shared helpers of the port framer control
package spfc_pkg;

  // Register offsets, byte wide on the register port
  localparam logic [7:0] ADDR_RX_FRAMING = 8'hA5;
  localparam logic [7:0] ADDR_RX_FILTER  = 8'hA6;
  localparam logic [7:0] ADDR_RX_LOCK    = 8'hA7;
  localparam logic [7:0] ADDR_RX_ALIGNER = 8'hA8;
  localparam logic [7:0] ADDR_TX_FRAMING = 8'hA9;
  localparam logic [7:0] ADDR_TX_STATUS  = 8'hAA;
  localparam logic [7:0] ADDR_PAR_COUNT  = 8'hB0;

  // Reset value and writable bits of the control registers
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] RFC_MASK  = 8'h7F;
  localparam logic [7:0] RFL_MASK  = 8'h09;
  localparam logic [7:0] TFC_MASK  = 8'hEF;

  // Receive framing control fields
  localparam int RFC_RELOCK  = 0;
  localparam int RFC_FRAME   = 1;
  localparam int RFC_PATH_LO = 2;
  localparam int RFC_PATH_HI = 3;
  localparam int RFC_BYPASS  = 4;
  localparam int RFC_HALT    = 5;
  localparam int RFC_PAR_EN  = 6;

  // Receive filter control fields
  localparam int RFL_OH_ONLY  = 0;
  localparam int RFL_PASS_ALL = 3;

  // Transmit framing config fields
  localparam int TFC_PTR     = 0;
  localparam int TFC_TEST    = 1;
  localparam int TFC_FRAME   = 2;
  localparam int TFC_SCR     = 3;
  localparam int TFC_SYNC    = 5;
  localparam int TFC_TYPE_LO = 6;
  localparam int TFC_TYPE_HI = 7;

  // Receive rate select and data path codes
  localparam logic [1:0] RATE_OC48 = 2'h0;
  localparam logic [1:0] RATE_GBE  = 2'h1;
  localparam logic [1:0] RATE_OC12 = 2'h2;
  localparam logic [1:0] RATE_OC3  = 2'h3;
  localparam logic [1:0] PATH_FIFO = 2'h1;

  // Frame geometry and overhead bytes
  localparam logic [6:0] ROW_BYTES = 7'h5A;
  localparam logic [3:0] ROWS      = 4'h9;
  localparam logic [6:0] OH_COLS   = 7'h03;
  localparam logic [6:0] A1_COL    = 7'h00;
  localparam logic [6:0] A2_COL    = 7'h01;
  localparam logic [3:0] ROW_FIRST = 4'h0;
  localparam logic [3:0] B1_ROW    = 4'h1;
  localparam logic [3:0] PTR_ROW   = 4'h3;
  localparam logic [7:0] A1        = 8'hF6;
  localparam logic [7:0] A2        = 8'h28;
  localparam logic [7:0] H1_NORMAL = 8'h60;
  localparam logic [7:0] H1_NDF    = 8'h90;
  localparam logic [7:0] H2_ZERO   = 8'h00;
  localparam logic [7:0] OH_FILL   = 8'h00;

  // Aligner thresholds, scrambler seed, counter ceiling
  localparam logic [1:0] HITS_TO_LOCK = 2'h3;
  localparam logic [1:0] MISS_TO_DROP = 2'h3;
  localparam logic [6:0] SCR_SEED     = 7'h7F;
  localparam logic [7:0] PAR_MAX      = 8'hFF;

  // Next byte position inside the frame, as {row, col}
  function automatic logic [10:0] pos_next(input logic [3:0] row,
                                           input logic [6:0] col);
    if (col != ROW_BYTES - 7'h01) begin
      return {row, col + 7'h01};
    end
    if (row == ROWS - 4'h1) begin
      return {ROW_FIRST, A1_COL};
    end
    return {row + 4'h1, A1_COL};
  endfunction

  // Byte sits in the first-row overhead, which is never scrambled
  function automatic logic in_row0_oh(input logic [3:0] row,
                                      input logic [6:0] col);
    return (row == ROW_FIRST) && (col < OH_COLS);
  endfunction

  // Eight steps of the 1 + x^6 + x^7 scrambler, as {key, next state}
  function automatic logic [14:0] scr_step(input logic [6:0] s);
    logic [6:0] st;
    logic [7:0] k;
    st = s;
    k  = 8'h00;
    for (int i = 7; i >= 0; i--) begin
      k[i] = st[6];
      st   = {st[5:0], st[6] ^ st[5]};
    end
    return {k, st};
  endfunction

  // Number of set bits in a byte
  function automatic logic [3:0] ones(input logic [7:0] v);
    logic [3:0] n;
    n = 4'h0;
    for (int i = 0; i < 8; i++) begin
      n = n + {3'h0, v[i]};
    end
    return n;
  endfunction

endpackage

//--- verilog/spfc_aligner.sv
// Receive frame aligner: pattern search, verify, lock and position
`timescale 1ns/1ns
module spfc_aligner (
  // Clock and reset
  input  wire logic       i_clock,
  input  wire logic       i_rst,
  // Received byte stream
  input  wire logic       i_valid,
  input  wire logic [7:0] i_data,
  // Hold in search while high
  input  wire logic       i_relock,
  // Aligner status
  output logic            o_locked,
  output logic            o_found,
  output logic [1:0]      o_miss,
  output logic [1:0]      o_hit,
  output logic            o_byte_sync,
  output logic            o_bit_sync,
  // Position of the byte now on i_data
  output logic [3:0]      o_row,
  output logic [6:0]      o_col
);

  typedef enum logic [1:0] {AL_SEARCH, AL_VERIFY, AL_LOCKED} spfc_align_e;

  typedef struct packed {
    spfc_align_e state;
    logic [3:0]  row;
    logic [6:0]  col;
    logic [7:0]  prev;
    logic [1:0]  hit;
    logic [1:0]  miss;
    logic        found;
    logic        byte_sync;
    logic        bit_sync;
  } spfc_align_s;

  localparam spfc_align_s ALIGN_RST = '{state: AL_SEARCH, default: '0};

  spfc_align_s r;
  spfc_align_s n;
  logic        pat;
  logic        at_check;
  logic [3:0]  prow;
  logic [6:0]  pcol;

  // Search, then check the pattern once per frame until lock or loss
  always_comb begin
    n        = r;
    pat      = (r.prev == spfc_pkg::A1) && (i_data == spfc_pkg::A2);
    at_check = (r.row == spfc_pkg::ROW_FIRST) && (r.col == spfc_pkg::A2_COL);
    {prow, pcol} = spfc_pkg::pos_next(r.row, r.col);
    if (i_relock) begin
      n = ALIGN_RST;
    end else if (i_valid) begin
      n.prev = i_data;
      n.row  = prow;
      n.col  = pcol;
      if (i_data == spfc_pkg::A1) begin
        n.bit_sync = 1'b1;
      end
      if (pat) begin
        n.byte_sync = 1'b1;
      end
      case (r.state)
        AL_SEARCH: begin
          if (pat) begin
            n.state = AL_VERIFY;
            n.row   = spfc_pkg::ROW_FIRST;
            n.col   = spfc_pkg::A2_COL + 7'h01;
            n.hit   = 2'h1;
            n.miss  = 2'h0;
            n.found = 1'b1;
          end
        end
        AL_VERIFY, AL_LOCKED: begin
          if (at_check && pat) begin
            n.found = 1'b1;
            n.miss  = 2'h0;
            if (r.hit != spfc_pkg::HITS_TO_LOCK) begin
              n.hit = r.hit + 2'h1;
            end
            if (r.hit == spfc_pkg::HITS_TO_LOCK - 2'h1) begin
              n.state = AL_LOCKED;
            end
          end else if (at_check) begin
            n.found = 1'b0;
            n.hit   = 2'h0;
            if (r.miss != spfc_pkg::MISS_TO_DROP) begin
              n.miss = r.miss + 2'h1;
            end
            // One miss aborts a verify; a lock needs repeated misses
            if (r.state == AL_VERIFY ||
                r.miss == spfc_pkg::MISS_TO_DROP - 2'h1) begin
              n.state = AL_SEARCH;
            end
          end
        end
        default: n.state = AL_SEARCH;
      endcase
    end
  end

  // State register
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      r <= ALIGN_RST;
    end else begin
      r <= n;
    end
  end

  // Status taps
  assign o_locked    = (r.state == AL_LOCKED);
  assign o_found     = r.found;
  assign o_miss      = r.miss;
  assign o_hit       = r.hit;
  assign o_byte_sync = r.byte_sync;
  assign o_bit_sync  = r.bit_sync;
  assign o_row       = r.row;
  assign o_col       = r.col;

endmodule

//--- verilog/spfc_top.sv
// Port framer control: registers, receive acquisition, transmit framer
//
// Operation
// - Parity errors counted while enabled, else zero
// - Overflow with halt bit stops acquisition
// - Bypass stops descrambling, only when framed
// - Ethernet: bypass bit disables line decoder
// - Path field: direct, through FIFO, test
// - Framing on: acquire locked, descrambled; else raw
// - Ethernet: frame enable bit aligns data
// - Relock bit high then low: drop, relock
// - Ethernet: pass idles and command symbols
// - Overhead only: capture overhead, drop payload
// - Lock in status bit 0, aligner bit 7
// - Read-only pattern found flag
// - Two-bit mismatch and match tallies
// - Byte sync and bit sync flags
// - Sync trigger bit starts trigger output
// - Scramble transmit data when frame detected
// - Local framing with BIP, host payload only
// - Test bit sends test data instead
// - Pointer bit low then high: pointer reset
// - Transmit framed flag when frame seen
// - Rate select codes OC48, GbE, OC12, OC3
`timescale 1ns/1ns
module spfc_top (
  // Clock and reset
  input  wire logic       I_CLOCK,
  input  wire logic       I_RST,
  // Register port
  input  wire logic [7:0] I_ADDR,
  input  wire logic [7:0] I_WDATA,
  input  wire logic       I_WR,
  input  wire logic       I_RD,
  output logic [7:0]      O_RDATA,
  // Line rate setting from the line configuration
  input  wire logic [1:0] I_RATE_SELECT,
  // Received line bytes
  input  wire logic       I_RX_VALID,
  input  wire logic [7:0] I_RX_DATA,
  // Acquisition side
  input  wire logic       I_FIFO_OVERFLOW,
  output logic            O_ACQ_VALID,
  output logic [7:0]      O_ACQ_DATA,
  output logic            O_ACQ_VIA_FIFO,
  output logic            O_ACQ_TEST,
  // Ethernet receive controls
  output logic            O_DECODER_BYPASS,
  output logic            O_ETH_ALIGN,
  output logic            O_PASS_ALL,
  // Transmit host data
  input  wire logic       I_TX_VALID,
  input  wire logic [7:0] I_TX_DATA,
  output logic            O_TX_READY,
  // Transmit line side
  output logic            O_TX_VALID,
  output logic [7:0]      O_TX_DATA,
  output logic [1:0]      O_TX_FRAME_TYPE,
  output logic            O_TX_SYNC_TRIGGER,
  output logic            O_PTR_RESET_CMD
);

  typedef struct packed {
    logic [7:0] rx_ctl;
    logic [7:0] rx_flt;
    logic [7:0] tx_cfg;
    logic [7:0] rdata;
    logic [7:0] par_cnt;
    logic       halted;
    logic [6:0] rx_scr;
    logic [7:0] rx_bip;
    logic [7:0] rx_bip_prev;
    logic       acq_valid;
    logic [7:0] acq_data;
    logic [7:0] rx_test;
    logic [3:0] tx_row;
    logic [6:0] tx_col;
    logic [6:0] tx_scr;
    logic [7:0] tx_bip;
    logic [7:0] tx_bip_prev;
    logic [7:0] tx_prev;
    logic [7:0] tx_test;
    logic [7:0] tx_data;
    logic       tx_valid;
    logic       tx_framed;
    logic       ptr_pend;
    logic       sync_pulse;
    logic       ptr_pulse;
  } spfc_state_s;

  spfc_state_s r;
  spfc_state_s n;

  // Aligner taps
  logic       al_locked;
  logic       al_found;
  logic [1:0] al_miss;
  logic [1:0] al_hit;
  logic       al_byte_sync;
  logic       al_bit_sync;
  logic [3:0] al_row;
  logic [6:0] al_col;

  // Working terms of the combinational process
  logic       is_eth;
  logic       frame_en;
  logic       rx_oh;
  logic       rx_descr;
  logic [7:0] rx_key;
  logic [6:0] rx_scr_n;
  logic [7:0] rx_byte;
  logic [3:0] b1_err;
  logic [8:0] par_sum;
  logic       rx_take;
  logic [7:0] tx_key;
  logic [6:0] tx_scr_n;
  logic [3:0] tx_nrow;
  logic [6:0] tx_ncol;
  logic       tx_local;
  logic       tx_test_on;
  logic       tx_step;
  logic       tx_pat;
  logic       tx_scr_on;
  logic [7:0] tx_raw;
  logic [7:0] tx_out;
  logic       tx_ready;

  spfc_aligner u_aligner (
    .i_clock     (I_CLOCK),
    .i_rst       (I_RST),
    .i_valid     (I_RX_VALID),
    .i_data      (I_RX_DATA),
    .i_relock    (r.rx_ctl[spfc_pkg::RFC_RELOCK]),
    .o_locked    (al_locked),
    .o_found     (al_found),
    .o_miss      (al_miss),
    .o_hit       (al_hit),
    .o_byte_sync (al_byte_sync),
    .o_bit_sync  (al_bit_sync),
    .o_row       (al_row),
    .o_col       (al_col)
  );

  // Mode decode; gigabit ethernet reuses framing bits for the decoder
  assign is_eth   = (I_RATE_SELECT == spfc_pkg::RATE_GBE);
  assign frame_en = r.rx_ctl[spfc_pkg::RFC_FRAME] && !is_eth;
  assign tx_local   = r.tx_cfg[spfc_pkg::TFC_FRAME];
  assign tx_test_on = r.tx_cfg[spfc_pkg::TFC_TEST];
  // Local framing takes host bytes only in payload columns
  assign tx_ready = !tx_test_on &&
                    (!tx_local || (r.tx_col >= spfc_pkg::OH_COLS));

  // Next state of the whole block
  always_comb begin
    n            = r;
    n.rdata      = spfc_pkg::REG_RESET;
    n.sync_pulse = 1'b0;
    n.ptr_pulse  = 1'b0;
    n.acq_valid  = 1'b0;

    // Register writes; reserved bits never stick
    if (I_WR) begin
      case (I_ADDR)
        spfc_pkg::ADDR_RX_FRAMING: n.rx_ctl = I_WDATA & spfc_pkg::RFC_MASK;
        spfc_pkg::ADDR_RX_FILTER:  n.rx_flt = I_WDATA & spfc_pkg::RFL_MASK;
        spfc_pkg::ADDR_TX_FRAMING: begin
          n.tx_cfg     = I_WDATA & spfc_pkg::TFC_MASK;
          n.sync_pulse = I_WDATA[spfc_pkg::TFC_SYNC] &&
                         !r.tx_cfg[spfc_pkg::TFC_SYNC];
          n.ptr_pulse  = I_WDATA[spfc_pkg::TFC_PTR] &&
                         !r.tx_cfg[spfc_pkg::TFC_PTR];
        end
        default: ;
      endcase
    end

    // Register reads, answered in the next cycle
    if (I_RD) begin
      case (I_ADDR)
        spfc_pkg::ADDR_RX_FRAMING: n.rdata = r.rx_ctl;
        spfc_pkg::ADDR_RX_FILTER:  n.rdata = r.rx_flt;
        spfc_pkg::ADDR_RX_LOCK:    n.rdata = {7'h00, al_locked};
        spfc_pkg::ADDR_RX_ALIGNER:
          n.rdata = {al_locked, al_found, al_miss, al_hit,
                     al_byte_sync, al_bit_sync};
        spfc_pkg::ADDR_TX_FRAMING: n.rdata = r.tx_cfg;
        spfc_pkg::ADDR_TX_STATUS:  n.rdata = {7'h00, r.tx_framed};
        spfc_pkg::ADDR_PAR_COUNT:  n.rdata = r.par_cnt;
        default:                   n.rdata = spfc_pkg::REG_RESET;
      endcase
    end

    // Receive descrambling of locked frames
    {rx_key, rx_scr_n} = spfc_pkg::scr_step(r.rx_scr);
    rx_oh    = spfc_pkg::in_row0_oh(al_row, al_col);
    rx_descr = frame_en && al_locked && !rx_oh &&
               !r.rx_ctl[spfc_pkg::RFC_BYPASS];
    rx_byte  = rx_descr ? (I_RX_DATA ^ rx_key) : I_RX_DATA;
    b1_err   = 4'h0;
    if (I_RX_VALID && al_locked) begin
      if (al_row == spfc_pkg::ROW_FIRST &&
          al_col == spfc_pkg::OH_COLS - 7'h01) begin
        n.rx_scr = spfc_pkg::SCR_SEED;
      end else begin
        n.rx_scr = rx_scr_n;
      end
      // Parity runs over the line bytes as received
      if (al_row == spfc_pkg::ROWS - 4'h1 &&
          al_col == spfc_pkg::ROW_BYTES - 7'h01) begin
        n.rx_bip_prev = r.rx_bip ^ I_RX_DATA;
        n.rx_bip      = 8'h00;
      end else begin
        n.rx_bip = r.rx_bip ^ I_RX_DATA;
      end
      if (frame_en && al_row == spfc_pkg::B1_ROW &&
          al_col == spfc_pkg::A1_COL) begin
        b1_err = spfc_pkg::ones(rx_byte ^ r.rx_bip_prev);
      end
    end

    // Parity error counter, saturating
    par_sum = {1'b0, r.par_cnt} + {5'h00, b1_err};
    if (!r.rx_ctl[spfc_pkg::RFC_PAR_EN]) begin
      n.par_cnt = 8'h00;
    end else if (par_sum[8]) begin
      n.par_cnt = spfc_pkg::PAR_MAX;
    end else begin
      n.par_cnt = par_sum[7:0];
    end

    // Halt clears with its enable or a relock; a new overflow wins
    if (!n.rx_ctl[spfc_pkg::RFC_HALT] ||
        n.rx_ctl[spfc_pkg::RFC_RELOCK]) begin
      n.halted = 1'b0;
    end
    if (r.rx_ctl[spfc_pkg::RFC_HALT] && I_FIFO_OVERFLOW) begin
      n.halted = 1'b1;
    end

    // Acquisition gate; overhead filter only means something when framed
    rx_take = I_RX_VALID && !r.halted && (!frame_en || al_locked);
    if (frame_en && r.rx_flt[spfc_pkg::RFL_OH_ONLY] &&
        al_col >= spfc_pkg::OH_COLS) begin
      rx_take = 1'b0;
    end
    if (r.rx_ctl[spfc_pkg::RFC_PATH_HI]) begin
      n.acq_valid = !r.halted;
      n.acq_data  = r.rx_test;
      n.rx_test   = r.rx_test + 8'h01;
    end else if (rx_take) begin
      n.acq_valid = 1'b1;
      n.acq_data  = rx_byte;
    end

    // Transmit: test data, local framing or host passthrough
    {tx_key, tx_scr_n} = spfc_pkg::scr_step(r.tx_scr);
    {tx_nrow, tx_ncol} = spfc_pkg::pos_next(r.tx_row, r.tx_col);
    tx_step = tx_test_on || tx_local || I_TX_VALID;
    tx_raw  = I_TX_DATA;
    if (tx_test_on) begin
      tx_raw    = r.tx_test;
      n.tx_test = r.tx_test + 8'h01;
    end else if (tx_local && r.tx_col < spfc_pkg::OH_COLS) begin
      tx_raw = spfc_pkg::OH_FILL;
      if (r.tx_row == spfc_pkg::ROW_FIRST &&
          r.tx_col == spfc_pkg::A1_COL) begin
        tx_raw = spfc_pkg::A1;
      end else if (r.tx_row == spfc_pkg::ROW_FIRST) begin
        tx_raw = (r.tx_col == spfc_pkg::A2_COL) ? spfc_pkg::A2 :
                                                  spfc_pkg::OH_FILL;
      end else if (r.tx_row == spfc_pkg::B1_ROW &&
                   r.tx_col == spfc_pkg::A1_COL) begin
        tx_raw = r.tx_bip_prev;
      end else if (r.tx_row == spfc_pkg::PTR_ROW &&
                   r.tx_col == spfc_pkg::A1_COL) begin
        tx_raw = r.ptr_pend ? spfc_pkg::H1_NDF :
                              spfc_pkg::H1_NORMAL;
        n.ptr_pend = 1'b0;
      end else if (r.tx_row == spfc_pkg::PTR_ROW &&
                   r.tx_col == spfc_pkg::A2_COL) begin
        tx_raw = spfc_pkg::H2_ZERO;
      end
    end else if (!I_TX_VALID) begin
      tx_raw = spfc_pkg::OH_FILL;
    end

    // Frame detection in outgoing data keeps the position in step
    tx_pat = (r.tx_prev == spfc_pkg::A1) && (tx_raw == spfc_pkg::A2);
    if (tx_step) begin
      n.tx_prev = tx_raw;
      n.tx_row  = tx_nrow;
      n.tx_col  = tx_ncol;
      if (tx_local) begin
        n.tx_framed = 1'b1;
      end else if (tx_pat) begin
        n.tx_framed = 1'b1;
        n.tx_row    = spfc_pkg::ROW_FIRST;
        n.tx_col    = spfc_pkg::A2_COL + 7'h01;
      end else if (r.tx_row == spfc_pkg::ROW_FIRST &&
                   r.tx_col == spfc_pkg::A2_COL) begin
        n.tx_framed = 1'b0;
      end
    end

    // Scrambling, first-row overhead left clear for the far aligner
    tx_scr_on = r.tx_cfg[spfc_pkg::TFC_SCR] && !tx_test_on &&
                (tx_local || r.tx_framed) &&
                !spfc_pkg::in_row0_oh(r.tx_row, r.tx_col);
    tx_out = tx_scr_on ? (tx_raw ^ tx_key) : tx_raw;
    if (tx_step) begin
      if (r.tx_row == spfc_pkg::ROW_FIRST &&
          r.tx_col == spfc_pkg::OH_COLS - 7'h01) begin
        n.tx_scr = spfc_pkg::SCR_SEED;
      end else begin
        n.tx_scr = tx_scr_n;
      end
      // Parity of this frame goes out in the next frame
      if (r.tx_row == spfc_pkg::ROWS - 4'h1 &&
          r.tx_col == spfc_pkg::ROW_BYTES - 7'h01) begin
        n.tx_bip_prev = r.tx_bip ^ tx_out;
        n.tx_bip      = 8'h00;
      end else begin
        n.tx_bip = r.tx_bip ^ tx_out;
      end
    end
    n.tx_data  = tx_out;
    n.tx_valid = tx_step;

    // A fresh command request wins over the one just sent
    if (n.ptr_pulse) begin
      n.ptr_pend = 1'b1;
    end
  end

  // State register
  always_ff @(posedge I_CLOCK or posedge I_RST) begin
    if (I_RST) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  // Outputs
  assign O_RDATA           = r.rdata;
  assign O_ACQ_VALID       = r.acq_valid;
  assign O_ACQ_DATA        = r.acq_data;
  assign O_ACQ_VIA_FIFO    = (r.rx_ctl[spfc_pkg::RFC_PATH_HI:
                              spfc_pkg::RFC_PATH_LO] ==
                              spfc_pkg::PATH_FIFO);
  assign O_ACQ_TEST        = r.rx_ctl[spfc_pkg::RFC_PATH_HI];
  assign O_DECODER_BYPASS  = is_eth &&
                             r.rx_ctl[spfc_pkg::RFC_BYPASS];
  assign O_ETH_ALIGN       = is_eth &&
                             r.rx_ctl[spfc_pkg::RFC_FRAME];
  assign O_PASS_ALL        = is_eth &&
                             r.rx_flt[spfc_pkg::RFL_PASS_ALL];
  assign O_TX_READY        = tx_ready;
  assign O_TX_VALID        = r.tx_valid;
  assign O_TX_DATA         = r.tx_data;
  assign O_TX_FRAME_TYPE   = r.tx_cfg[spfc_pkg::TFC_TYPE_HI:
                                      spfc_pkg::TFC_TYPE_LO];
  assign O_TX_SYNC_TRIGGER = r.sync_pulse;
  assign O_PTR_RESET_CMD   = r.ptr_pulse;

endmodule

//--- tb/spfc_props.sv
// Port level assertions of the port framer control
`timescale 1ns/1ns
module spfc_props (
  // Clock and reset
  input wire logic       I_CLOCK,
  input wire logic       I_RST,
  // Register port
  input wire logic [7:0] I_ADDR,
  input wire logic [7:0] I_WDATA,
  input wire logic       I_WR,
  input wire logic       I_RD,
  input wire logic [7:0] O_RDATA,
  // Mode levels
  input wire logic [1:0] I_RATE_SELECT,
  input wire logic       O_ACQ_VIA_FIFO,
  input wire logic       O_ACQ_TEST,
  input wire logic       O_DECODER_BYPASS,
  input wire logic       O_ETH_ALIGN,
  input wire logic       O_PASS_ALL,
  // Transmit pulses
  input wire logic       O_TX_SYNC_TRIGGER,
  input wire logic       O_PTR_RESET_CMD
);
  default clocking cb @(posedge I_CLOCK); endclocking
  default disable iff (I_RST);
  // Read data only in the cycle after a read strobe
  property p_rd0; !$past(I_RD) |-> O_RDATA == 8'h00; endproperty
  a_rd0: assert property (p_rd0) else $error("stray read data");
  // Pulses only follow a write of the transmit config
  property p_sync;
    O_TX_SYNC_TRIGGER |-> $past(I_WR && I_ADDR == 8'hA9 && I_WDATA[5]);
  endproperty
  a_sync: assert property (p_sync) else $error("stray trigger");
  property p_ptr;
    O_PTR_RESET_CMD |-> $past(I_WR && I_ADDR == 8'hA9 && I_WDATA[0]);
  endproperty
  a_ptr: assert property (p_ptr) else $error("stray pointer cmd");
  // One command per rising edge, never a level
  property p_one; O_PTR_RESET_CMD |=> !O_PTR_RESET_CMD; endproperty
  a_one: assert property (p_one) else $error("long pointer cmd");
  // Ethernet controls exist only at the gigabit rate
  property p_dec; O_DECODER_BYPASS |-> I_RATE_SELECT == 2'h1; endproperty
  a_dec: assert property (p_dec) else $error("bypass off rate");
  property p_aln; O_ETH_ALIGN |-> I_RATE_SELECT == 2'h1; endproperty
  a_aln: assert property (p_aln) else $error("align off rate");
  property p_pass; O_PASS_ALL |-> I_RATE_SELECT == 2'h1; endproperty
  a_pass: assert property (p_pass) else $error("pass off rate");
  // Path codes exclude each other
  property p_path; O_ACQ_VIA_FIFO |-> !O_ACQ_TEST; endproperty
  a_path: assert property (p_path) else $error("two paths");
endmodule

//--- tb/spfc_line_model.sv
// Line side source of framed receive bytes
`timescale 1ns/1ns
module spfc_line_model (
  // Clock and reset
  input  wire logic       i_clock,
  input  wire logic       i_rst,
  // Byte stream toward the framer
  output logic            o_valid,
  output logic [7:0]      o_data
);
  logic [9:0] pos_r;
  // 810 byte frames; ramp payload changes every byte
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      pos_r <= 10'h000;
    end else begin
      pos_r <= (pos_r == 10'h329) ? 10'h000 : pos_r + 10'h001;
    end
  end
  assign o_valid = !i_rst;
  assign o_data  = (pos_r == 10'h000) ? spfc_pkg::A1 :
                   (pos_r == 10'h001) ? spfc_pkg::A2 : pos_r[7:0];
endmodule

//--- tb/tb_spfc_top.sv
// Register level test of the port framer control
`timescale 1ns/1ns
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin error_cnt++; \
  $display("unexpected at %0t: %h not %h", $time, (a), (e)); end end
module tb_spfc_top;
  logic       I_CLOCK = 0, I_RST = 1, I_WR = 0, I_RD = 0, I_RX_VALID;
  logic       I_FIFO_OVERFLOW = 0, I_TX_VALID = 0, O_TX_READY, O_TX_VALID;
  logic       O_ACQ_VALID, O_ACQ_VIA_FIFO, O_ACQ_TEST, O_DECODER_BYPASS;
  logic       O_ETH_ALIGN, O_PASS_ALL, O_TX_SYNC_TRIGGER, O_PTR_RESET_CMD;
  logic [7:0] I_ADDR = 0, I_WDATA = 0, I_TX_DATA = 0, I_RX_DATA, O_RDATA;
  logic [7:0] O_ACQ_DATA, O_TX_DATA;
  logic [1:0] I_RATE_SELECT = 0, O_TX_FRAME_TYPE;
  int         error_cnt = 0, checks = 0;
  spfc_top dut_u (.*);
  spfc_line_model line_u (.i_clock(I_CLOCK), .i_rst(I_RST),
                          .o_valid(I_RX_VALID), .o_data(I_RX_DATA));
  always #5 I_CLOCK = !I_CLOCK;
  // Register port cycles; read data taken where it stands
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge I_CLOCK);
    {I_ADDR, I_WDATA, I_WR} <= {a, d, 1'b1};
    @(posedge I_CLOCK);
    I_WR <= 1'b0;
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    @(posedge I_CLOCK);
    {I_ADDR, I_RD} <= {a, 1'b1};
    @(posedge I_CLOCK);
    I_RD <= 1'b0;
    #1 `CHK(O_RDATA, e)
  endtask
  // Lock takes three frames; poll with a bound
  task automatic lockwait();
    repeat (40) begin
      repeat (100) @(posedge I_CLOCK);
      {I_ADDR, I_RD} <= {8'hA7, 1'b1};
      @(posedge I_CLOCK);
      I_RD <= 1'b0;
      // Read data stands only in this cycle
      #1 if (O_RDATA === 8'h01) break;
    end
    rc(8'hA7, 8'h01);
  endtask
  task automatic end_of_test();
    if (error_cnt == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    #400000;
    error_cnt++;
    end_of_test();
  end
  bit [7:0] d;
  int       n;
  // Main sequence
  initial begin
    repeat (3) @(posedge I_CLOCK);
    I_RST <= 1'b0;
    rc(8'hA5, 8'h00);
    rc(8'hA9, 8'h00);
    rc(8'h00, 8'h00);
    wr(8'hA5, 8'hFF);
    rc(8'hA5, 8'h7F);
    wr(8'hA6, 8'hFF);
    rc(8'hA6, 8'h09);
    wr(8'hA7, 8'hFF);
    rc(8'hA7, 8'h00);
    wr(8'hA5, 8'h04);
    #1 `CHK(O_ACQ_VIA_FIFO, 1'b1)
    wr(8'hA5, 8'h08);
    #1 `CHK(O_ACQ_TEST, 1'b1)
    I_RATE_SELECT <= 2'h1;
    wr(8'hA5, 8'h12);
    #1 `CHK({O_DECODER_BYPASS, O_ETH_ALIGN}, 2'h3)
    `CHK(O_PASS_ALL, 1'b1)
    I_RATE_SELECT <= 2'h0;
    wr(8'hA6, 8'h00);
    #1 `CHK({O_ETH_ALIGN, O_PASS_ALL}, 2'h0)
    wr(8'hA5, 8'h00);
    #1 d = I_RX_DATA;
    @(posedge I_CLOCK);
    #1 `CHK({O_ACQ_VALID, O_ACQ_DATA}, {1'b1, d})
    wr(8'hA5, 8'h20);
    I_FIFO_OVERFLOW <= 1'b1;
    wr(8'hA9, 8'h20);
    #1 `CHK(O_TX_SYNC_TRIGGER, 1'b1)
    I_FIFO_OVERFLOW <= 1'b0;
    @(posedge I_CLOCK);
    #1 `CHK({O_TX_SYNC_TRIGGER, O_ACQ_VALID}, 2'h0)
    wr(8'hA9, 8'h21);
    #1 `CHK({O_TX_SYNC_TRIGGER, O_PTR_RESET_CMD}, 2'h1)
    wr(8'hA9, 8'h40);
    wr(8'hA5, 8'h00);
    // Halt drops at the write edge; first byte taken one edge later
    @(posedge I_CLOCK);
    #1 `CHK({O_TX_FRAME_TYPE, O_ACQ_VALID}, 3'h3)
    @(posedge I_CLOCK);
    {I_TX_VALID, I_TX_DATA} <= {1'b1, 8'hAA};
    @(posedge I_CLOCK);
    I_TX_VALID <= 1'b0;
    #1 `CHK({O_TX_VALID, O_TX_DATA}, {1'b1, 8'hAA})
    wr(8'hA9, 8'h02);
    #1 `CHK(O_TX_READY, 1'b0)
    wr(8'hA9, 8'h04);
    for (int i = 0; i < 900 && !(d === 8'hF6 && O_TX_DATA === 8'h28); i++)
    begin
      d = O_TX_DATA;
      @(posedge I_CLOCK);
      #1;
    end
    `CHK(O_TX_DATA, spfc_pkg::A2)
    rc(8'hAA, 8'h01);
    wr(8'hA5, 8'h42);
    lockwait();
    rc(8'hA8, 8'hCF);
    // Locked and framed, bypass set: acquired bytes stay raw
    wr(8'hA5, 8'h52);
    #1 d = I_RX_DATA;
    @(posedge I_CLOCK);
    #1 `CHK({O_ACQ_VALID, O_ACQ_DATA}, {1'b1, d})
    wr(8'hA5, 8'h02);
    rc(8'hB0, 8'h00);
    wr(8'hA6, 8'h01);
    n = 0;
    repeat (810) begin
      @(posedge I_CLOCK);
      #1 n += O_ACQ_VALID;
    end
    `CHK(n, 27)
    wr(8'hA5, 8'h03);
    rc(8'hA7, 8'h00);
    wr(8'hA5, 8'h02);
    lockwait();
    end_of_test();
  end
endmodule
bind spfc_top spfc_props props_u (.*);
